// ---- shared/supervision_timer_pkg.sv ----
/*
  Shared constants and types for the supervision timer with mode lock.
  Assumes a 100 MHz crystal-rate clock and an on-chip RC oscillator that
  is modelled as a one-cycle tick enable derived from that clock.
*/
package supervision_timer_pkg;

  // Crystal clock period and RC oscillator period, in ns.
  localparam int CLK_PERIOD_NS = 10;
  localparam int RC_PERIOD_NS  = 1000;
  localparam int RC_DIV        = RC_PERIOD_NS / CLK_PERIOD_NS;

  // Register location in the expanded register file.
  localparam logic [3:0] MODE_BANK = 4'hF;
  localparam logic [7:0] MODE_ADDR = 8'h0F;

  // Mode register field positions and reset value.
  localparam int TAP_LSB  = 0;
  localparam int HALT_BIT = 2;
  localparam int STOP_BIT = 3;
  localparam logic [7:0] MODE_RESET = 8'h0C;
  localparam logic [7:0] READ_VALUE = 8'h00;

  // Write window: 60 processor cycles of two crystal clocks each.
  localparam int WINDOW_CPU_CYCLES = 60;
  localparam int WINDOW_CLKS       = WINDOW_CPU_CYCLES * 2;

  // Minimum timeouts per tap, in ms, and their RC tick counts.
  localparam int TAP0_MS = 10;
  localparam int TAP1_MS = 20;
  localparam int TAP2_MS = 40;
  localparam int TAP3_MS = 160;
  localparam int MS_NS   = 1000000;
  localparam int TAP0_TICKS = TAP0_MS * (MS_NS / RC_PERIOD_NS);
  localparam int TAP1_TICKS = TAP1_MS * (MS_NS / RC_PERIOD_NS);
  localparam int TAP2_TICKS = TAP2_MS * (MS_NS / RC_PERIOD_NS);
  localparam int TAP3_TICKS = TAP3_MS * (MS_NS / RC_PERIOD_NS);

  // Power-on delay in RC ticks and the short reset length in clocks.
  localparam int POR_TICKS       = 5000;
  localparam int SHORT_RESET_CLKS = 18;

  localparam int CNT_W = 24;

  typedef struct packed {
    logic [3:0] reserved;
    logic       stop_run;
    logic       halt_run;
    logic [1:0] tap;
  } mode_t;

  typedef struct packed {
    logic we;
    logic zero;
    logic sign;
    logic overflow;
  } flags_t;

  typedef enum logic [1:0] {
    WAIT_FIRST,
    OPEN,
    LOCKED
  } window_t;

endpackage

// ---- rtl/rc_tick_divider.sv ----
/*
  Divider that stands in for the on-chip RC oscillator.
  Assumes one clock; emits a one-cycle tick every DIV clocks.
*/
`timescale 1ns/1ps
module rc_tick_divider #(
  parameter int DIV = 100
) (
  input  wire logic clk,
  input  wire logic rstn,
  output logic      tick
);

  logic [15:0] count;
  logic [15:0] next_count;
  logic        next_tick;

  always_comb begin
    if (count == 16'(DIV - 1)) begin
      next_count = 16'h0000;
      next_tick  = 1'b1;
    end else begin
      next_count = count + 16'h0001;
      next_tick  = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

endmodule

// ---- rtl/supervision_timer.sv ----
/*
  Supervision timer with a mode register that locks shortly after reset.
  Assumes the core supplies same-clock pulses for the watchdog instruction,
  the first instruction after reset or recovery and stop recovery, plus
  halt and stop levels. The two clear inputs are asynchronous pins.
*/
// Notes on behaviour
// - Retriggerable one-shot; terminal count asserts a device reset.
// - Idle until first watchdog instruction arms it; later ones refresh it.
// - The counter advances on the RC oscillator tick, not crystal clock.
// - The watchdog instruction sets the we flag and clears zero, sign and overflow.
// - The power-on timer also counts RC oscillator ticks.
// - Mode writable 120 clocks after first instruction; locked after that.
// - Mode register is write-only; reads never return its contents.
// - Bits 1:0 pick minimum timeout of 10, 20, 40 or 160 ms.
// - Bit 2 set keeps the timer running in halt; defaults to one.
// - Bit 3 set keeps the timer running in stop; defaults to one.
// - Bits 7 to 4 are reserved and do nothing.
// - A build option decides whether the timer runs from power-on.
// - Clear one rise starts timers; clear two rise starts short reset.
`timescale 1ns/1ps
module supervision_timer #(
  parameter logic        RUN_AT_POWER_ON = 1'b0,
  parameter logic [23:0] TAP0_TICKS = 24'(supervision_timer_pkg::TAP0_TICKS),
  parameter logic [23:0] TAP1_TICKS = 24'(supervision_timer_pkg::TAP1_TICKS),
  parameter logic [23:0] TAP2_TICKS = 24'(supervision_timer_pkg::TAP2_TICKS),
  parameter logic [23:0] TAP3_TICKS = 24'(supervision_timer_pkg::TAP3_TICKS),
  parameter logic [23:0] POR_TICKS  = 24'(supervision_timer_pkg::POR_TICKS)
) (
  input  wire logic           clk,
  input  wire logic           rstn,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  input  wire logic [3:0]     reg_bank,
  input  wire logic [7:0]     reg_addr,
  input  wire logic [7:0]     reg_wdata,
  output logic [7:0]          reg_rdata,
  input  wire logic           wdt_instr,
  input  wire logic           first_instr,
  input  wire logic           stop_recovery,
  input  wire logic           halt_mode,
  input  wire logic           stop_mode,
  input  wire logic           timer_start_clear_one,
  input  wire logic           short_reset_start_clear,
  output logic                device_reset,
  output logic                por_done,
  output supervision_timer_pkg::flags_t flags
);

  localparam int CW = supervision_timer_pkg::CNT_W;

  logic rc_tick;

  rc_tick_divider #(
    .DIV (supervision_timer_pkg::RC_DIV)
  ) u_rc (
    .clk  (clk),
    .rstn (rstn),
    .tick (rc_tick)
  );

  // Clear pins come from outside; two flops, then edge detect on stage two.
  logic [1:0] c1_sync, c2_sync;
  logic       c1_prev, c2_prev;
  logic       c1_rise, c2_rise;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      c1_sync <= 2'h0;
      c2_sync <= 2'h0;
      c1_prev <= 1'b0;
      c2_prev <= 1'b0;
    end else begin
      c1_sync <= {c1_sync[0], timer_start_clear_one};
      c2_sync <= {c2_sync[0], short_reset_start_clear};
      c1_prev <= c1_sync[1];
      c2_prev <= c2_sync[1];
    end
  end

  assign c1_rise = c1_sync[1] & ~c1_prev;
  assign c2_rise = c2_sync[1] & ~c2_prev;

  // Mode register and its write window.
  supervision_timer_pkg::mode_t   mode, next_mode;
  supervision_timer_pkg::window_t win, next_win;
  logic [7:0] win_cnt, next_win_cnt;
  logic [7:0] next_rdata;
  logic       hit;

  assign hit = (reg_bank == supervision_timer_pkg::MODE_BANK) &&
               (reg_addr == supervision_timer_pkg::MODE_ADDR);

  always_comb begin
    next_mode    = mode;
    next_win     = win;
    next_win_cnt = win_cnt;
    next_rdata   = reg_rdata;
    if (reg_rd) begin
      next_rdata = supervision_timer_pkg::READ_VALUE;
    end
    if (reg_wr && hit && win == supervision_timer_pkg::OPEN) begin
      next_mode          = reg_wdata;
      next_mode.reserved = 4'h0;
    end
    case (win)
      supervision_timer_pkg::WAIT_FIRST: begin
        if (first_instr) begin
          next_win     = supervision_timer_pkg::OPEN;
          next_win_cnt = 8'h00;
        end
      end
      supervision_timer_pkg::OPEN: begin
        next_win_cnt = win_cnt + 8'h01;
        if (win_cnt == 8'(supervision_timer_pkg::WINDOW_CLKS - 1)) begin
          next_win = supervision_timer_pkg::LOCKED;
        end
      end
      default: begin
        next_win = supervision_timer_pkg::LOCKED;
      end
    endcase
    // Stop recovery or any device reset reopens the window at the next
    // first instruction.
    if (stop_recovery || device_reset) begin
      next_win = supervision_timer_pkg::WAIT_FIRST;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode      <= supervision_timer_pkg::MODE_RESET;
      win       <= supervision_timer_pkg::WAIT_FIRST;
      win_cnt   <= 8'h00;
      reg_rdata <= 8'h00;
    end else begin
      mode      <= next_mode;
      win       <= next_win;
      win_cnt   <= next_win_cnt;
      reg_rdata <= next_rdata;
    end
  end

  // Watchdog counter, power-on timer and short reset timer.
  logic          started, next_started;
  logic          armed, next_armed;
  logic [CW-1:0] count, next_count;
  logic [CW-1:0] por_cnt, next_por_cnt;
  logic          next_por_done;
  logic [4:0]    rst_cnt, next_rst_cnt;
  logic          next_reset;
  logic [CW-1:0] limit;
  logic          paused;
  supervision_timer_pkg::flags_t next_flags;

  always_comb begin
    case (mode.tap)
      2'h0:    limit = TAP0_TICKS;
      2'h1:    limit = TAP1_TICKS;
      2'h2:    limit = TAP2_TICKS;
      default: limit = TAP3_TICKS;
    endcase
  end

  // The count freezes rather than clears so a short halt does not buy time.
  assign paused = (halt_mode && !mode.halt_run) ||
                  (stop_mode && !mode.stop_run);

  always_comb begin
    next_started  = started | c1_rise;
    next_armed    = armed;
    next_count    = count;
    next_por_cnt  = por_cnt;
    next_por_done = por_done;
    next_rst_cnt  = rst_cnt;
    next_reset    = device_reset;
    next_flags    = '0;
    if (wdt_instr) begin
      next_armed = 1'b1;
      next_count = '0;
      next_flags.we = 1'b1;
    end else if (armed && started && rc_tick && !paused) begin
      // One extra tick covers the partial first RC period, so the selected
      // timeout is a true minimum and never a tick short.
      if (count >= limit) begin
        next_count   = '0;
        next_armed   = RUN_AT_POWER_ON;
        next_reset   = 1'b1;
        next_rst_cnt = 5'h00;
      end else begin
        next_count = count + 24'h000001;
      end
    end
    if (started && !por_done && rc_tick) begin
      next_por_cnt = por_cnt + 24'h000001;
      if (por_cnt >= POR_TICKS - 24'h000001) begin
        next_por_done = 1'b1;
      end
    end
    if (c2_rise) begin
      next_reset   = 1'b1;
      next_rst_cnt = 5'h00;
    end else if (device_reset && !next_reset) begin
      next_rst_cnt = rst_cnt;
    end else if (device_reset) begin
      if (rst_cnt == 5'(supervision_timer_pkg::SHORT_RESET_CLKS - 1)) begin
        next_reset = 1'b0;
      end else begin
        next_rst_cnt = rst_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      started      <= 1'b0;
      armed        <= RUN_AT_POWER_ON;
      count        <= '0;
      por_cnt      <= '0;
      por_done     <= 1'b0;
      rst_cnt      <= 5'h00;
      device_reset <= 1'b0;
      flags        <= '0;
    end else begin
      started      <= next_started;
      armed        <= next_armed;
      count        <= next_count;
      por_cnt      <= next_por_cnt;
      por_done     <= next_por_done;
      rst_cnt      <= next_rst_cnt;
      device_reset <= next_reset;
      flags        <= next_flags;
    end
  end

endmodule

// ---- tb/supervision_timer_props.sv ----
/*
  Port checker for the supervision timer.
  Assumes it is bound to the top module and that the timer runs on clk.
*/
`timescale 1ns/1ps
module supervision_timer_props #(
  parameter logic [23:0] TAP0_TICKS = 24'h4
) (
  input wire logic                          clk,
  input wire logic                          rstn,
  input wire logic [7:0]                    reg_rdata,
  input wire logic                          wdt_instr,
  input wire logic                          timer_start_clear_one,
  input wire logic                          short_reset_start_clear,
  input wire logic                          device_reset,
  input wire logic                          por_done,
  input wire supervision_timer_pkg::flags_t flags
);
  logic [15:0] since;
  logic [3:0]  age2;
  logic [4:0]  hi;
  logic        arm;
  logic        short_reset_start_clear_q;
  logic        timer_start_clear_one_seen;

  // The short tap is the earliest that a refresh may end in a reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      since     <= '0;
      age2      <= 4'hF;
      hi        <= '0;
      arm       <= 1'b0;
      short_reset_start_clear_q    <= 1'b0;
      timer_start_clear_one_seen <= 1'b0;
    end else begin
      since     <= wdt_instr ? '0 : since + {15'h0, since != 16'hFFFF};
      age2      <= (short_reset_start_clear && !short_reset_start_clear_q) ? '0 :
                   age2 + {3'h0, age2 != 4'hF};
      hi        <= device_reset ? hi + 5'h1 : '0;
      arm       <= arm | wdt_instr;
      short_reset_start_clear_q    <= short_reset_start_clear;
      timer_start_clear_one_seen <= timer_start_clear_one_seen | timer_start_clear_one;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_rdata_zero; reg_rdata == 8'h00; endproperty
  a_rdata_zero: assert property (p_rdata_zero)
    else $error("read leaks");
  property p_flags_set; wdt_instr |=> flags == 4'h8; endproperty
  a_flags_set: assert property (p_flags_set)
    else $error("flags wrong");
  property p_flags_cause; flags.we |-> $past(wdt_instr); endproperty
  a_flags_cause: assert property (p_flags_cause)
    else $error("stray flags");
  property p_reset_len; $fell(device_reset) |-> hi == 5'h12; endproperty
  a_reset_len: assert property (p_reset_len)
    else $error("reset length");
  property p_clear_two;
    $rose(short_reset_start_clear) |-> ##[1:6] device_reset;
  endproperty
  a_clear_two: assert property (p_clear_two)
    else $error("no short reset");
  // A watchdog reset may only follow a full shortest timeout of RC ticks.
  property p_reset_cause;
    $rose(device_reset) |-> age2 < 4'h8 ||
      (arm && since > 16'(TAP0_TICKS * supervision_timer_pkg::RC_DIV));
  endproperty
  a_reset_cause: assert property (p_reset_cause)
    else $error("early reset");
  property p_por_sticky; por_done |=> por_done; endproperty
  a_por_sticky: assert property (p_por_sticky)
    else $error("por dropped");
  property p_por_cause; $rose(por_done) |-> timer_start_clear_one_seen; endproperty
  a_por_cause: assert property (p_por_cause)
    else $error("por uncleared");
endmodule

bind supervision_timer supervision_timer_props #(
  .TAP0_TICKS(TAP0_TICKS)
) u_supervision_timer_props (
  .clk                     (clk),
  .rstn                    (rstn),
  .reg_rdata               (reg_rdata),
  .wdt_instr               (wdt_instr),
  .timer_start_clear_one   (timer_start_clear_one),
  .short_reset_start_clear (short_reset_start_clear),
  .device_reset            (device_reset),
  .por_done                (por_done),
  .flags                   (flags)
);

// ---- tb/testbench.sv ----
/*
  Self-checking bench for the supervision timer.
  Assumes short tap counts and the design's 100-clock RC tick.
*/
`timescale 1ns/1ps
module testbench;
  logic       clk, rstn, reg_wr, reg_rd, wdt_instr, first_instr;
  logic       stop_recovery, halt_mode, stop_mode, device_reset, por_done;
  logic       timer_start_clear_one, short_reset_start_clear;
  logic [3:0] reg_bank;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  supervision_timer_pkg::flags_t flags;
  int         err_count, checked, i;
  // Halt level, stop level, then the mode byte; taps 4 to 7 ticks.
  logic [9:0] rows [4] = '{10'h0F0, 10'h205, 10'h10A, 10'h00F};

  supervision_timer #(
    .TAP0_TICKS(24'h4), .TAP1_TICKS(24'h5), .TAP2_TICKS(24'h6),
    .TAP3_TICKS(24'h7), .POR_TICKS(24'h3)
  ) u_supervision_timer (
    .clk                     (clk),
    .rstn                    (rstn),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_bank                (reg_bank),
    .reg_addr                (reg_addr),
    .reg_wdata               (reg_wdata),
    .reg_rdata               (reg_rdata),
    .wdt_instr               (wdt_instr),
    .first_instr             (first_instr),
    .stop_recovery           (stop_recovery),
    .halt_mode               (halt_mode),
    .stop_mode               (stop_mode),
    .timer_start_clear_one   (timer_start_clear_one),
    .short_reset_start_clear (short_reset_start_clear),
    .device_reset            (device_reset),
    .por_done                (por_done),
    .flags                   (flags)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(logic [23:0] got, logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk) #1 s = 1'b1;
    @(posedge clk) #1 s = 1'b0;
  endtask
  task automatic wr(logic [7:0] d, logic [7:0] a);
    reg_wdata = d;
    reg_addr = a;
    pulse(reg_wr);
  endtask
  task automatic open();
    pulse(stop_recovery);
    pulse(first_instr);
  endtask
  task automatic arm();
    pulse(wdt_instr);
    chk(flags, 4'h8);
  endtask
  task automatic quiet(int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk) #1;
      if (device_reset !== 1'b0) seen = 1'b1;
    end
    chk(seen, 1'b0);
  endtask
  task automatic hit(int n);
    int len;
    len = 0;
    for (i = 0; i < n && device_reset !== 1'b1; i++) @(posedge clk) #1;
    chk(device_reset, 1'b1);
    while (device_reset === 1'b1 && len < 40) begin
      @(posedge clk) #1;
      len++;
    end
    chk(len, 18);
  endtask
  task automatic expire(logic [1:0] tap);
    // No reset within the full tap; at most one RC period more for phase.
    quiet((4 + tap) * 100);
    hit(110);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    end_sim();
  end

  initial begin
    {rstn, reg_wr, reg_rd, wdt_instr, first_instr, stop_recovery} = '0;
    {halt_mode, stop_mode, timer_start_clear_one} = '0;
    short_reset_start_clear = 1'b0;
    reg_bank = supervision_timer_pkg::MODE_BANK;
    reg_addr = supervision_timer_pkg::MODE_ADDR;
    reg_wdata = '0;
    err_count = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    chk({device_reset, por_done, flags, reg_rdata}, '0);
    #1 rstn = 1'b1;
    @(posedge clk) #1 timer_start_clear_one = 1'b1;
    quiet(900);
    chk(por_done, 1'b1);
    foreach (rows[r]) begin
      open();
      wr(rows[r][7:0], supervision_timer_pkg::MODE_ADDR);
      halt_mode = rows[r][9];
      stop_mode = rows[r][8];
      arm();
      expire(rows[r][1:0]);
      halt_mode = 1'b0;
      stop_mode = 1'b0;
    end
    // A stray address and a late write must both leave tap 0 in force.
    open();
    wr(8'hFC, supervision_timer_pkg::MODE_ADDR);
    wr(8'h03, 8'h0E);
    pulse(reg_rd);
    chk(reg_rdata, 8'h00);
    repeat (125) @(posedge clk);
    #1;
    wr(8'h03, supervision_timer_pkg::MODE_ADDR);
    arm();
    expire(2'h0);
    arm();
    quiet(250);
    arm();
    expire(2'h0);
    open();
    wr(8'h00, supervision_timer_pkg::MODE_ADDR);
    arm();
    // Ticks banked before the pause make a cleared count show up late.
    quiet(250);
    halt_mode = 1'b1;
    quiet(800);
    halt_mode = 1'b0;
    stop_mode = 1'b1;
    quiet(800);
    stop_mode = 1'b0;
    hit(300);
    @(posedge clk) #1 short_reset_start_clear = 1'b1;
    hit(8);
    end_sim();
  end
endmodule
